/* File: design/slt_defs.svh */
// constants for the switch lookup table access block
`ifndef SLT_DEFS_SVH
`define SLT_DEFS_SVH

// indirect access control fields
`define SLT_CTL_RD_BIT 12
`define SLT_CTL_SEL_HI 11
`define SLT_CTL_SEL_LO 10
`define SLT_CTL_IDX_HI 9
`define SLT_SEL_STATIC 2'h0
`define SLT_SEL_VLAN 2'h1
`define SLT_SEL_DYN 2'h2

// data register selects for host writes
`define SLT_DSEL_TOP 3'h1
`define SLT_DSEL_WORD_B 3'h2
`define SLT_DSEL_WORD_C 3'h3
`define SLT_DSEL_LOW 3'h4
`define SLT_DSEL_HIGH 3'h5

// table sizes
`define SLT_STATIC_DEPTH 8
`define SLT_STATIC_AW 3
`define SLT_VLAN_DEPTH 16
`define SLT_VLAN_AW 4
`define SLT_DYN_DEPTH 1024
`define SLT_DYN_AW 10
`define SLT_DYN_W 56

// static entry fields
`define SLT_ST_FID_HI 57
`define SLT_ST_FID_LO 54
`define SLT_ST_USEFID 53
`define SLT_ST_OVR 52
`define SLT_ST_VALID 51
`define SLT_ST_FWD_HI 50
`define SLT_ST_FWD_LO 48

// vlan entry fields and reset value
`define SLT_VL_VALID 19
`define SLT_VL_MEM_HI 18
`define SLT_VL_MEM_LO 16
`define SLT_VL_FID_HI 15
`define SLT_VL_FID_LO 12
`define SLT_VL_RST 20'hf0001

// dynamic entry fields as stored
`define SLT_DY_TS_HI 55
`define SLT_DY_TS_LO 54
`define SLT_DY_PORT_HI 53
`define SLT_DY_PORT_LO 52
`define SLT_DY_KEY_HI 51

// top byte of a dynamic read result
`define SLT_TOP_NRDY 7
`define SLT_TOP_EMPTY 2
`define SLT_TOP_RST 8'h04

`endif

/* File: design/slt_dyn_mem.sv */
// learned address memory with registered read data
`timescale 1ns/10ps
module slt_dyn_mem import slt_pkg::*; #(
	parameter int DEPTH = 1024,
	parameter int AW = 10,
	parameter int DW = 56
) (
	input wire logic clk_sys,
	slt_mem_if.mem bus
);
	logic [DW-1:0] store [DEPTH];

	if (DEPTH > (1 << AW))
	begin : g_chk
		$error("slt_dyn_mem depth exceeds address range");
	end

	// write, or read into the output register
	always_ff @(posedge clk_sys)
	begin
		if (bus.en && bus.we)
			store[bus.addr] <= bus.wdata;
		else if (bus.en)
			bus.rdata <= store[bus.addr];
	end
endmodule : slt_dyn_mem

/* File: design/slt_mem_if.sv */
// one-port access to the learned address memory
`timescale 1ns/10ps
interface slt_mem_if #(parameter int AW = 10, parameter int DW = 56);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport user (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : slt_mem_if

/* File: design/slt_pkg.sv */
// types shared by the lookup table access modules
package slt_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_DYN_CAP, ST_PKT_VLAN, ST_PKT_DA, ST_PKT_SA} slt_state_t;
	typedef logic [57:0] slt_static_entry_t;
	typedef logic [19:0] slt_vlan_entry_t;
endpackage : slt_pkg

/* File: design/slt_table_access.sv */
// indirect access and lookup logic for the switch address and vlan tables
`timescale 1ns/10ps
`include "slt_defs.svh"
module slt_table_access import slt_pkg::*; #(
	parameter int AGE_TICK_CYCLES = 50000000
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ctrlWr,
	input wire logic [15:0] ctrlData,
	input wire logic dataWr,
	input wire logic [2:0] dataSel,
	input wire logic [15:0] dataWrVal,
	input wire logic vlanModeEn,
	input wire logic [35:0] portDefaultVid,
	input wire logic pktValid,
	input wire logic [1:0] pktPort,
	input wire logic pktTagged,
	input wire logic [11:0] pktVid,
	input wire logic [47:0] pktDa,
	input wire logic [47:0] pktSa,
	output logic pktReady,
	output logic accBusy,
	output logic [7:0] indirectDataTopByte,
	output logic [15:0] indirectDataWordC,
	output logic [15:0] indirectDataWordB,
	output logic [15:0] indirectDataHighWord,
	output logic [15:0] indirectDataLowWord,
	output logic fwdValid,
	output logic fwdDrop,
	output logic [2:0] fwdPorts
);
	if (AGE_TICK_CYCLES < 1)
	begin : g_chk
		$error("slt_table_access age tick must be at least one cycle");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [`SLT_DYN_AW-1:0] hashIdx(input logic [3:0] filter_identifier,
		input logic [47:0] mac);
		hashIdx = mac[`SLT_DYN_AW-1:0] ^ {filter_identifier, 6'h00};
	endfunction : hashIdx

	function automatic logic [2:0] portBit(input logic [1:0] port);
		portBit = 3'h0;
		case (port)
			2'h0: portBit = 3'h1;
			2'h1: portBit = 3'h2;
			2'h2: portBit = 3'h4;
			default: portBit = 3'h0;
		endcase
	endfunction : portBit

	// flood set: vlan members without the ingress port
	function automatic logic [2:0] curMemberMasked(input logic [2:0] mem,
		input logic [1:0] port);
		curMemberMasked = mem & ~portBit(port);
	endfunction : curMemberMasked

	// ----------------------------------------------------------------
	// reset release and state
	// ----------------------------------------------------------------
	logic [1:0] rstPipe;
	logic rstN;
	slt_state_t stateReg, stateNext;
	logic [15:0] ctrlReg;
	logic pendReg;
	slt_static_entry_t staticTbl [`SLT_STATIC_DEPTH];
	slt_vlan_entry_t vlanTbl [`SLT_VLAN_DEPTH];
	logic [`SLT_VLAN_DEPTH*20-1:0] vlanFlat;
	logic [`SLT_DYN_DEPTH-1:0] dynValid;
	logic [`SLT_DYN_AW:0] validCount;
	logic [31:0] ageCnt;
	logic ageTick;
	logic [1:0] ageStamp;
	logic [1:0] pPort;
	logic [47:0] pDa, pSa;
	logic [11:0] pVid;
	logic [3:0] fidReg;
	logic [2:0] memberReg;
	logic dynDaHitReg;
	logic [1:0] dynDaPortReg;
	logic [`SLT_DYN_AW-1:0] capIdxReg;
	slt_mem_if #(.AW(`SLT_DYN_AW), .DW(`SLT_DYN_W)) memBus ();

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'h1};
	end
	assign rstN = rstPipe[1];

	// ----------------------------------------------------------------
	// control word decode
	// ----------------------------------------------------------------
	logic serve, ctlRead, srvStRd, srvStWr, srvVlRd, srvVlWr, srvDynRd, take;
	logic [1:0] ctlSel;
	logic [`SLT_DYN_AW-1:0] ctlIdx;
	slt_static_entry_t staticSel, wrEntry;
	slt_vlan_entry_t vlanSel;
	logic [9:0] countField;

	assign ctlRead = ctrlReg[`SLT_CTL_RD_BIT];
	assign ctlSel = ctrlReg[`SLT_CTL_SEL_HI:`SLT_CTL_SEL_LO];
	assign ctlIdx = ctrlReg[`SLT_CTL_IDX_HI:0];
	assign serve = (stateReg == ST_IDLE) && pendReg;
	assign srvStRd = serve && ctlRead && (ctlSel == `SLT_SEL_STATIC);
	assign srvStWr = serve && !ctlRead && (ctlSel == `SLT_SEL_STATIC);
	assign srvVlRd = serve && ctlRead && (ctlSel == `SLT_SEL_VLAN);
	assign srvVlWr = serve && !ctlRead && (ctlSel == `SLT_SEL_VLAN);
	assign srvDynRd = serve && ctlRead && (ctlSel == `SLT_SEL_DYN);
	assign staticSel = staticTbl[ctlIdx[`SLT_STATIC_AW-1:0]];
	assign vlanSel = vlanTbl[ctlIdx[`SLT_VLAN_AW-1:0]];
	assign wrEntry = {indirectDataWordC[9:0], indirectDataWordB, indirectDataHighWord,
		indirectDataLowWord};
	assign countField = (validCount == '0) ? 10'h000 : 10'(validCount - 11'h001);
	assign pktReady = (stateReg == ST_IDLE) && !pendReg;
	assign take = pktValid && pktReady;
	assign accBusy = pendReg || (stateReg == ST_DYN_CAP);

	// latch the control word; a pending access is launched when idle
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			ctrlReg <= 16'h0000;
			pendReg <= 1'h0;
		end
		else
		begin
			if (serve)
				pendReg <= 1'h0;
			if (ctrlWr)
			begin
				ctrlReg <= ctrlData;
				pendReg <= 1'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// static and vlan tables
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			for (int i = 0; i < `SLT_STATIC_DEPTH; i++)
				staticTbl[i] <= '0;
			for (int i = 0; i < `SLT_VLAN_DEPTH; i++)
				vlanTbl[i] <= `SLT_VL_RST;
		end
		else
		begin
			if (srvStWr)
				staticTbl[ctlIdx[`SLT_STATIC_AW-1:0]] <= wrEntry;
			if (srvVlWr)
				vlanTbl[ctlIdx[`SLT_VLAN_AW-1:0]] <= {indirectDataHighWord[3:0], indirectDataLowWord};
		end
	end

	for (genvar i = 0; i < `SLT_VLAN_DEPTH; i++)
	begin : g_flat
		assign vlanFlat[i*20 +: 20] = vlanTbl[i];
	end

	// ----------------------------------------------------------------
	// indirect data registers
	// ----------------------------------------------------------------
	logic [`SLT_DYN_W-1:0] dynRd;
	assign dynRd = dynValid[capIdxReg] ? memBus.rdata : '0;

	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			indirectDataTopByte <= `SLT_TOP_RST;
			indirectDataWordC <= 16'h0000;
			indirectDataWordB <= 16'h0000;
			indirectDataHighWord <= 16'h0000;
			indirectDataLowWord <= 16'h0000;
		end
		else
		begin
			// host loads of the data words
			if (dataWr && dataSel == `SLT_DSEL_WORD_C)
				indirectDataWordC <= dataWrVal;
			if (dataWr && dataSel == `SLT_DSEL_WORD_B)
				indirectDataWordB <= dataWrVal;
			if (dataWr && dataSel == `SLT_DSEL_HIGH)
				indirectDataHighWord <= dataWrVal;
			if (dataWr && dataSel == `SLT_DSEL_LOW)
				indirectDataLowWord <= dataWrVal;
			// static read result
			if (srvStRd)
			begin
				indirectDataWordC <= {6'h00, staticSel[57:48]};
				indirectDataWordB <= staticSel[47:32];
				indirectDataHighWord <= staticSel[31:16];
				indirectDataLowWord <= staticSel[15:0];
			end
			// vlan read result
			if (srvVlRd)
			begin
				indirectDataHighWord <= {12'h000, vlanSel[19:16]};
				indirectDataLowWord <= vlanSel[15:0];
			end
			// learned entry result, status fields first
			if (stateReg == ST_DYN_CAP)
			begin
				indirectDataTopByte <= {5'h00, (validCount == '0), countField[9:8]};
				indirectDataWordC <= {countField[7:0], dynRd[55:48]};
				indirectDataWordB <= dynRd[47:32];
				indirectDataHighWord <= dynRd[31:16];
				indirectDataLowWord <= dynRd[15:0];
			end
			// not ready is raised by a new request and wins over the capture
			if (srvDynRd || (ctrlWr && ctrlData[`SLT_CTL_RD_BIT]
				&& ctrlData[`SLT_CTL_SEL_HI:`SLT_CTL_SEL_LO] == `SLT_SEL_DYN))
				indirectDataTopByte[`SLT_TOP_NRDY] <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// aging timestamp divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			ageCnt <= 32'h0;
			ageTick <= 1'h0;
			ageStamp <= 2'h0;
		end
		else
		begin
			ageTick <= (ageCnt == 32'(AGE_TICK_CYCLES - 1));
			ageCnt <= (ageCnt == 32'(AGE_TICK_CYCLES - 1)) ? 32'h0 : ageCnt + 32'h1;
			if (ageTick)
				ageStamp <= ageStamp + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// packet lookup
	// ----------------------------------------------------------------
	logic vlanHit, dropNow, saHit, stHit;
	slt_vlan_entry_t vlanEntry;
	logic [3:0] curFid;
	logic [2:0] curMember, stFwd, stFwdMasked, fwdCalc;
	logic [`SLT_DYN_AW-1:0] saIdx;

	slt_vlan_match #(.N(`SLT_VLAN_DEPTH)) u_vlan_match (
		.tableFlat(vlanFlat),
		.vlan_identifier(pVid),
		.hit(vlanHit),
		.entry(vlanEntry)
	);

	assign dropNow = vlanModeEn && !(vlanHit && vlanEntry[`SLT_VL_VALID]);
	assign curFid = vlanModeEn ? vlanEntry[`SLT_VL_FID_HI:`SLT_VL_FID_LO] : 4'h0;
	assign curMember = vlanModeEn ? vlanEntry[`SLT_VL_MEM_HI:`SLT_VL_MEM_LO] : 3'h7;
	assign saIdx = hashIdx(fidReg, pSa);
	assign saHit = dynValid[saIdx]
		&& (memBus.rdata[`SLT_DY_KEY_HI:0] == {fidReg, pSa});

	// static search on destination, plus identifier when the entry's use-fid bit is set
	always_comb
	begin
		stHit = 1'h0;
		stFwd = 3'h0;
		for (int i = `SLT_STATIC_DEPTH - 1; i >= 0; i--)
		begin
			if ((staticTbl[i][`SLT_ST_VALID] || staticTbl[i][`SLT_ST_OVR])
				&& staticTbl[i][47:0] == pDa && (!staticTbl[i][`SLT_ST_USEFID]
				|| staticTbl[i][`SLT_ST_FID_HI:`SLT_ST_FID_LO] == fidReg))
			begin
				stHit = 1'h1;
				stFwd = staticTbl[i][`SLT_ST_FWD_HI:`SLT_ST_FWD_LO];
			end
		end
	end
	assign stFwdMasked = stFwd & ~portBit(pPort);
	assign fwdCalc = stHit ? stFwdMasked : (dynDaHitReg ? portBit(dynDaPortReg)
		: curMemberMasked(memberReg, pPort));

	// packet registers and lookup results
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			pPort <= 2'h0;
			pDa <= 48'h0;
			pSa <= 48'h0;
			pVid <= 12'h000;
			fidReg <= 4'h0;
			memberReg <= 3'h0;
			dynDaHitReg <= 1'h0;
			dynDaPortReg <= 2'h0;
			capIdxReg <= '0;
		end
		else
		begin
			if (take)
			begin
				pPort <= pktPort;
				pDa <= pktDa;
				pSa <= pktSa;
				pVid <= (pktTagged && pktVid != 12'h000) ? pktVid
					: portDefaultVid[pktPort*12 +: 12];
			end
			if (srvDynRd)
				capIdxReg <= ctlIdx;
			if (stateReg == ST_PKT_VLAN)
			begin
				fidReg <= curFid;
				memberReg <= curMember;
			end
			if (stateReg == ST_PKT_DA)
			begin
				dynDaHitReg <= dynValid[hashIdx(fidReg, pDa)]
					&& (memBus.rdata[`SLT_DY_KEY_HI:0] == {fidReg, pDa});
				dynDaPortReg <= memBus.rdata[`SLT_DY_PORT_HI:`SLT_DY_PORT_LO];
			end
		end
	end

	// forwarding result, one-cycle pulse
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			fwdValid <= 1'h0;
			fwdDrop <= 1'h0;
			fwdPorts <= 3'h0;
		end
		else
		begin
			fwdValid <= (stateReg == ST_PKT_SA) || (stateReg == ST_PKT_VLAN && dropNow);
			fwdDrop <= (stateReg == ST_PKT_VLAN) && dropNow;
			fwdPorts <= (stateReg == ST_PKT_SA) ? (fwdCalc & ~portBit(pPort)) : 3'h0;
		end
	end

	// learned table bookkeeping, only the learning path writes it
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			dynValid <= '0;
			validCount <= '0;
		end
		else if (stateReg == ST_PKT_SA && !saHit)
		begin
			dynValid[saIdx] <= 1'h1;
			if (!dynValid[saIdx])
				validCount <= validCount + 11'h001;
		end
	end

	// memory port use by the host read and the lookup steps
	always_comb
	begin
		memBus.en = 1'h0;
		memBus.we = 1'h0;
		memBus.addr = ctlIdx;
		memBus.wdata = '0;
		if (srvDynRd)
			memBus.en = 1'h1;
		case (stateReg)
			ST_PKT_VLAN:
			begin
				memBus.en = !dropNow;
				memBus.addr = hashIdx(curFid, pDa);
			end
			ST_PKT_DA:
			begin
				memBus.en = 1'h1;
				memBus.addr = saIdx;
			end
			ST_PKT_SA:
			begin
				memBus.en = !saHit;
				memBus.we = !saHit;
				memBus.addr = saIdx;
				memBus.wdata = {ageStamp, pPort, fidReg, pSa};
			end
			default: memBus.addr = ctlIdx;
		endcase
	end

	slt_dyn_mem #(.DEPTH(`SLT_DYN_DEPTH), .AW(`SLT_DYN_AW), .DW(`SLT_DYN_W)) u_dyn_mem (
		.clk_sys(clk_sys),
		.bus(memBus)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		stateNext = stateReg;
		case (stateReg)
			ST_IDLE:
				if (srvDynRd)
					stateNext = ST_DYN_CAP;
				else if (take)
					stateNext = ST_PKT_VLAN;
			ST_DYN_CAP: stateNext = ST_IDLE;
			ST_PKT_VLAN: stateNext = dropNow ? ST_IDLE : ST_PKT_DA;
			ST_PKT_DA: stateNext = ST_PKT_SA;
			ST_PKT_SA: stateNext = ST_IDLE;
			default: stateNext = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			stateReg <= ST_IDLE;
		else
			stateReg <= stateNext;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstN);

	sequence dynReadSteps;
		indirectDataTopByte[`SLT_TOP_NRDY] ##1 !indirectDataTopByte[`SLT_TOP_NRDY];
	endsequence

	a_static_read_map: assert property (srvStRd && !dataWr |=>
		indirectDataWordB == $past(staticSel[47:32])
		&& indirectDataWordC[9:0] == $past(staticSel[57:48]))
		else $error("static read map wrong");
	a_static_write: assert property (srvStWr && !ctrlWr |=> staticSel == $past(wrEntry))
		else $error("static write lost");
	a_dyn_readonly: assert property (memBus.we |-> stateReg == ST_PKT_SA)
		else $error("learned table written by host");
	a_dyn_ready_seq: assert property (srvDynRd && !ctrlWr |=> dynReadSteps)
		else $error("not ready flag timing");
	a_empty_count: assert property (stateReg == ST_DYN_CAP |=>
		indirectDataTopByte[`SLT_TOP_EMPTY] == ($past(validCount) == '0)
		&& indirectDataTopByte[1:0] == $past(countField[9:8]))
		else $error("empty or count field wrong");
	a_vlan_read_map: assert property (srvVlRd && !dataWr |=>
		indirectDataHighWord[3:0] == $past(vlanSel[19:16])
		&& indirectDataLowWord == $past(vlanSel[15:0]))
		else $error("vlan read map wrong");
	a_mode_off_pass: assert property (stateReg == ST_PKT_VLAN && !vlanModeEn |=>
		stateReg == ST_PKT_DA ##2 fwdValid && !fwdDrop)
		else $error("packet dropped with vlan mode off");
	a_drop_no_learn: assert property (stateReg == ST_PKT_VLAN && dropNow |=>
		fwdValid && fwdDrop && !memBus.we ##1 !memBus.we)
		else $error("dropped packet learned");
	a_flood_excl: assert property (fwdValid && !fwdDrop |->
		(fwdPorts & portBit(pPort)) == 3'h0)
		else $error("forward to ingress port");
	a_learn_miss: assert property (stateReg == ST_PKT_SA && !saHit |->
		memBus.we ##1 dynValid[$past(saIdx)])
		else $error("source miss not learned");
	a_static_prio: assert property (stateReg == ST_PKT_SA && stHit |=>
		fwdPorts == $past(stFwdMasked))
		else $error("static result not used");
endmodule : slt_table_access

/* File: design/slt_vlan_match.sv */
// search of the vlan table for an identifier
`timescale 1ns/10ps
`include "slt_defs.svh"
module slt_vlan_match import slt_pkg::*; #(
	parameter int N = 16
) (
	input wire logic [N*20-1:0] tableFlat,
	input wire logic [11:0] vlan_identifier,
	output logic hit,
	output slt_vlan_entry_t entry
);
	logic [N-1:0] match;

	if (N < 1)
	begin : g_chk
		$error("slt_vlan_match needs at least one entry");
	end

	// one comparator per entry
	for (genvar i = 0; i < N; i++)
	begin : g_cmp
		assign match[i] = (tableFlat[i*20 +: 12] == vlan_identifier);
	end

	// lowest matching entry wins
	always_comb
	begin
		hit = 1'h0;
		entry = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (match[i])
			begin
				hit = 1'h1;
				entry = tableFlat[i*20 +: 20];
			end
		end
	end
endmodule : slt_vlan_match

/* File: verif/tb.sv */
// self-checking bench for the lookup table access block
`timescale 1ns/10ps
module tb import slt_pkg::*; ;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic ctrlWr = 1'b0;
	logic [15:0] ctrlData = 16'h0;
	logic dataWr = 1'b0;
	logic [2:0] dataSel = 3'h0;
	logic [15:0] dataWrVal = 16'h0;
	logic vlanModeEn = 1'b0;
	logic [35:0] portDefaultVid = 36'h001001001;
	logic pktValid = 1'b0;
	logic [1:0] pktPort = 2'h0;
	logic pktTagged = 1'b0;
	logic [11:0] pktVid = 12'h0;
	logic [47:0] pktDa = 48'h0;
	logic [47:0] pktSa = 48'h0;
	logic pktReady, accBusy, fwdValid, fwdDrop;
	logic [7:0] top;
	logic [15:0] wc, wb, hi, lo, w;
	logic [2:0] fwdPorts;
	logic [31:0] lf = 32'h20;
	logic [47:0] addrA, addrB, addrD;
	logic [57:0] stEnt;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [51:0] learnQ[$]; // model of learned keys, filter identifier plus address

	slt_table_access #(.AGE_TICK_CYCLES(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
		.ctrlWr(ctrlWr), .ctrlData(ctrlData), .dataWr(dataWr), .dataSel(dataSel),
		.dataWrVal(dataWrVal), .vlanModeEn(vlanModeEn), .portDefaultVid(portDefaultVid),
		.pktValid(pktValid), .pktPort(pktPort), .pktTagged(pktTagged), .pktVid(pktVid),
		.pktDa(pktDa), .pktSa(pktSa), .pktReady(pktReady), .accBusy(accBusy),
		.indirectDataTopByte(top), .indirectDataWordC(wc), .indirectDataWordB(wb),
		.indirectDataHighWord(hi), .indirectDataLowWord(lo), .fwdValid(fwdValid),
		.fwdDrop(fwdDrop), .fwdPorts(fwdPorts));

	// 50 MHz clock and hang guard
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			conclude();
		end
	end

	// ----------------------------------------
	// helper tasks
	// ----------------------------------------
	task randWord(output logic [15:0] v);
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		v = lf[15:0];
	endtask : randWord

	task chkReg(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chkReg

	task chkFwd(input logic [3:0] exp);
		chkReg("forward result", {11'h0, 1'b1, exp}, {11'h0, fwdValid, fwdDrop, fwdPorts});
	endtask : chkFwd

	task ctrl(input logic [15:0] v);
		int n;
		@(posedge clk_sys) #1 ctrlWr = 1'b1;
		ctrlData = v;
		@(posedge clk_sys) #1 ctrlWr = 1'b0;
		if (v[12:10] == 3'h6)
			chkReg("not ready", 16'h1, {15'h0, top[7]});
		n = 0;
		while (accBusy !== 1'b0 && n < 20)
		begin
			@(posedge clk_sys) #1 n++;
		end
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : ctrl

	task dw(input logic [2:0] s, input logic [15:0] v);
		@(posedge clk_sys) #1 dataWr = 1'b1;
		dataSel = s;
		dataWrVal = v;
		@(posedge clk_sys) #1 dataWr = 1'b0;
	endtask : dw

	// learned read; count fields come from the bench's learn counter
	task dynRead(input logic [9:0] idx, input logic [7:0] wcLow, input logic [47:0] mac);
		logic [9:0] c;
		c = (learnQ.size() == 0) ? 10'h0 : 10'(learnQ.size() - 1);
		ctrl(16'h1800 | {6'h0, idx});
		chkReg("top byte", {8'h0, 5'h0, learnQ.size() == 0, c[9:8]}, {8'h0, top});
		chkReg("word c", {c[7:0], wcLow}, wc & 16'hff3f);
		chkReg("word b", mac[47:32], wb);
		chkReg("high word", mac[31:16], hi);
		chkReg("low word", mac[15:0], lo);
	endtask : dynRead

	task pkt(input logic [1:0] p, input logic t, input logic [11:0] v,
		input logic [47:0] da, input logic [47:0] sa, input logic [3:0] exp);
		int n;
		bit seen;
		n = 0;
		while (pktReady !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys) #1 n++;
		end
		pktValid = 1'b1;
		{pktPort, pktTagged, pktVid, pktDa, pktSa} = {p, t, v, da, sa};
		@(posedge clk_sys) #1 pktValid = 1'b0;
		n = 0;
		while (fwdValid !== 1'b1 && n < 10)
		begin
			@(posedge clk_sys) #1 n++;
		end
		chkFwd(exp);
		// model: a kept packet with a new source key is learned; bench vlans all use id 0
		seen = 1'b0;
		foreach (learnQ[i])
			if (learnQ[i] == {4'h0, sa})
				seen = 1'b1;
		if (!exp[3] && !seen)
			learnQ.push_back({4'h0, sa});
	endtask : pkt

	task conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#1 nrst = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chkReg("reset top", 16'h0004, {8'h0, top});
		ctrl(16'h1402);
		chkReg("vlan high", 16'h000f, hi);
		chkReg("vlan low", 16'h0001, lo);
		dynRead(10'h0, 8'h0, 48'h0);
		randWord(addrA[47:32]);
		randWord(addrA[31:16]);
		randWord(addrA[15:0]);
		randWord(w);
		addrB = addrA ^ 48'h1;
		addrD = {addrA[47:10] ^ {w, 22'h0}, ~addrA[9:0]};
		pkt(2'h1, 1'b0, 12'h0, addrD, addrA, 4'b0101);
		dynRead(addrA[9:0], 8'h10, addrA);
		dw(3'h4, 16'hffff);
		ctrl(16'h0800 | {6'h0, addrA[9:0]});
		dynRead(addrA[9:0], 8'h10, addrA);
		pkt(2'h0, 1'b0, 12'h0, addrA, addrD, 4'b0010);
		stEnt = {w[3:0], 3'b001, 3'b100, addrA};
		dw(3'h3, {6'h0, stEnt[57:48]});
		dw(3'h2, stEnt[47:32]);
		dw(3'h5, stEnt[31:16]);
		dw(3'h4, stEnt[15:0]);
		ctrl(16'h0007);
		ctrl(16'h1007);
		chkReg("static c", {6'h0, stEnt[57:48]}, wc);
		chkReg("static b", stEnt[47:32], wb);
		chkReg("static high", stEnt[31:16], hi);
		chkReg("static low", stEnt[15:0], lo);
		ctrl(16'h1001);
		chkReg("static one", 16'h0, wc | wb | hi | lo);
		pkt(2'h0, 1'b0, 12'h0, addrA, addrD, 4'b0100);
		pkt(2'h2, 1'b0, 12'h0, addrA, addrD, 4'b0000);
		vlanModeEn = 1'b1;
		dw(3'h5, 16'h0007);
		dw(3'h4, 16'h0005);
		ctrl(16'h0400);
		ctrl(16'h1400);
		chkReg("vlan0 high", 16'h0007, hi);
		chkReg("vlan0 low", 16'h0005, lo);
		pkt(2'h1, 1'b1, 12'h005, addrD, addrB, 4'b1000);
		dynRead(addrB[9:0], 8'h0, 48'h0);
		pkt(2'h2, 1'b0, 12'h0, addrB, addrA, 4'b0011);
		pkt(2'h1, 1'b1, 12'h000, addrB, addrA, 4'b0101);
		vlanModeEn = 1'b0;
		pkt(2'h1, 1'b1, 12'h005, addrB, addrA, 4'b0101);
		conclude();
	end
endmodule : tb
